//--- rtl/dco_top.sv
// Differential clock output control: gating, stop, divide and mode select with AXI4-Lite registers.
// Function
// - On stop release, restart stopped pairs together, within two to six output periods.
// - With stop tri-state set, drive true leg high within 15 ns of release; here one 50 ns clock cycle after the release is debounced.
// - Enable pins active high when strap is zero, active low when one.
// - Pair tri-stated unless both register bit and pin enable it.
// - Newly enabled pair restarts glitch-free within two to six output periods.
// - On enable, true leg driven high within 15 ns before toggling; here within one 50 ns reference clock cycle.
// - On disable, pair goes to tri-state glitch-free within two to six periods.
// - Half-rate register bit written zero selects half rate, else full rate.
// - Entering half rate switches all pairs glitch-free within two to six periods.
// - Leaving half rate returns all pairs glitch-free within two to six periods.
// - Bypass when register bit zero or bypass pin low; else PLL mode.
// - Bypass routes reference straight to outputs; PLL mode routes through PLL.
// - Wide bandwidth when register bit zero or bandwidth pin low.
// - Stop request accepted only after stable over two complement rising edges.
// - Polarity strap sampled once after reset, fixing input active levels.
// - Stopped pair parks: bit zero true high, complement float; bit one both float.
// - Pair disabled by enable stays tri-stated regardless of stop drive mode.
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module dco_top
  import dco_pkg::*;
#(
  parameter int NPAIRS = 4,
  parameter int NPINS = 2
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // Reference clock sampled as a level; in bypass the output legs are rebuilt from it.
  input wire logic REF_LEVEL_I,
  input wire logic PLL_LEVEL_I,
  input wire logic POLARITY_STRAP_I,
  input wire logic CLOCK_STOP_REQUEST_I,
  input wire logic POWER_DOWN_REQUEST_I,
  input wire logic [NPINS-1:0] OE_PIN_I,
  input wire logic PLL_SELECT_PIN_I,
  input wire logic WIDE_BANDWIDTH_SELECT_N_I,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [NPAIRS-1:0] TRUE_OUTPUT_LEG_O,
  output logic [NPAIRS-1:0] TRUE_OUTPUT_LEG_OE_O,
  output logic [NPAIRS-1:0] COMPLEMENT_OUTPUT_LEG_O,
  output logic [NPAIRS-1:0] COMPLEMENT_OUTPUT_LEG_OE_O,
  output logic BYPASS_MODE_O,
  output logic WIDE_BANDWIDTH_O,
  output logic POWER_DOWN_O
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NPAIRS < 1 || NPAIRS > 8) begin : g_chk_pairs
    $error("NPAIRS must be 1 to 8.");
  end
  if (NPINS < 1 || NPINS > NPAIRS) begin : g_chk_pins
    $error("NPINS must be 1 to NPAIRS.");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic strap_done;
    logic strap;
    logic [1:0] stop_sync;
    logic [1:0] pd_sync;
    logic [1:0] stop_hist;
    logic stop_acc;
    logic [1:0] src_sync;
    logic src_prev;
    logic div_ph;
    logic half_act;
    logic phase;
    logic [NPAIRS-1:0] run;
    logic [NPAIRS-1:0] tl;
    logic [NPAIRS-1:0] tl_oe;
    logic [NPAIRS-1:0] cl;
    logic [NPAIRS-1:0] cl_oe;
    dco_ctrl_t ctrl;
    logic [7:0] oe_reg;
    logic [7:0] stoppable;
    logic aw_hold;
    logic aw_rdy;
    logic [3:0] aw_addr;
    logic w_hold;
    logic w_rdy;
    logic [31:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic ar_rdy;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic bypass;
    logic wide_bw;
    logic pd;
  } dco_state_t;

  dco_state_t s_q;
  dco_state_t s_d;

  logic [NPAIRS-1:0] pin_en;
  logic [NPAIRS-1:0] want_run;
  logic [NPAIRS-1:0] want_stop;

  // Pairs beyond the pin count share the last pin.
  for (genvar i = 0; i < NPAIRS; i++) begin : g_pair
    localparam int PIN = (i < NPINS) ? i : NPINS - 1;
    // Pin polarity follows the strap latched after reset.
    assign pin_en[i] = OE_PIN_I[PIN] ^ s_q.strap;
    assign want_run[i] = pin_en[i] & s_q.oe_reg[i];
    assign want_stop[i] = s_q.stop_acc & s_q.stoppable[i];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic src_lvl;
    logic out_lvl;
    logic fall;
    logic rise_c;
    logic aw_go;
    logic w_go;
    dco_leg_mode_t mode;
    src_lvl = 1'b0;
    out_lvl = 1'b0;
    fall = 1'b0;
    rise_c = 1'b0;
    aw_go = 1'b0;
    w_go = 1'b0;
    mode = DCO_FLOAT;
    s_d = s_q;

    // ----------------------------------------------------------------
    // Polarity strap
    // ----------------------------------------------------------------
    // Strap is caught once on the first clock after reset release.
    if (!s_q.strap_done) begin
      s_d.strap = POLARITY_STRAP_I;
      s_d.strap_done = 1'b1;
    end

    // ----------------------------------------------------------------
    // Control inputs
    // ----------------------------------------------------------------
    // Two-stage synchronisers; only stage one feeds stage two.
    s_d.stop_sync = {s_q.stop_sync[0], CLOCK_STOP_REQUEST_I};
    s_d.pd_sync = {s_q.pd_sync[0], POWER_DOWN_REQUEST_I};
    s_d.pd = s_q.pd_sync[1] ^ ~s_q.strap;

    // ----------------------------------------------------------------
    // Output phase and divider
    // ----------------------------------------------------------------
    // Bypass routes the raw reference, PLL mode the PLL's clock.
    src_lvl = s_q.bypass ? REF_LEVEL_I : PLL_LEVEL_I;
    s_d.src_sync = {s_q.src_sync[0], src_lvl};
    fall = s_q.src_prev & ~s_q.src_sync[1];
    s_d.src_prev = s_q.src_sync[1];

    // Output phase: in half rate the divider toggles on every source fall and drives the output; in full rate it is held at zero.
    if (fall) begin
      s_d.div_ph = ~s_q.div_ph;
    end
    out_lvl = s_q.half_act ? s_q.div_ph : s_q.src_sync[1];
    s_d.phase = out_lvl;
    rise_c = s_q.phase & ~out_lvl;

    // ----------------------------------------------------------------
    // Stop debounce
    // ----------------------------------------------------------------
    // Stop request must hold over two complement rising edges.
    if (rise_c) begin
      s_d.stop_hist = {s_q.stop_hist[0], s_q.stop_sync[1] ^ ~s_q.strap};
      if (s_q.stop_hist[0] == (s_q.stop_sync[1] ^ ~s_q.strap)) begin
        s_d.stop_acc = s_q.stop_hist[0];
      end
    end

    // Divider and gating change only at true-leg low; no runt pulse.
    if (!out_lvl && s_q.phase) begin
      s_d.half_act = ~s_q.ctrl.half_rate_n;
      s_d.div_ph = 1'b0;
      for (int k = 0; k < NPAIRS; k++) begin
        s_d.run[k] = want_run[k] & ~want_stop[k] & ~s_q.pd;
      end
    end

    // ----------------------------------------------------------------
    // Leg drive
    // ----------------------------------------------------------------
    for (int k = 0; k < NPAIRS; k++) begin
      if (s_q.run[k]) begin
        mode = DCO_RUN;
      end else if (!want_run[k]) begin
        // Disabled pairs float whatever the stop drive mode is.
        mode = DCO_FLOAT;
      end else if (want_stop[k] && s_q.ctrl.stop_tri) begin
        mode = DCO_FLOAT;
      end else begin
        // Enabled but not yet running: true leg high within one cycle.
        mode = DCO_PARK_HI;
      end
      case (mode)
        DCO_RUN: begin
          s_d.tl[k] = out_lvl;
          s_d.tl_oe[k] = 1'b1;
          s_d.cl[k] = ~out_lvl;
          s_d.cl_oe[k] = 1'b1;
        end
        DCO_PARK_HI: begin
          s_d.tl[k] = 1'b1;
          s_d.tl_oe[k] = 1'b1;
          s_d.cl[k] = 1'b0;
          s_d.cl_oe[k] = 1'b0;
        end
        default: begin
          s_d.tl[k] = 1'b0;
          s_d.tl_oe[k] = 1'b0;
          s_d.cl[k] = 1'b0;
          s_d.cl_oe[k] = 1'b0;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Mode pins
    // ----------------------------------------------------------------
    s_d.bypass = ~s_q.ctrl.bypass_n | ~PLL_SELECT_PIN_I;
    s_d.wide_bw = ~s_q.ctrl.wide_bw_n | ~WIDE_BANDWIDTH_SELECT_N_I;

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    aw_go = S_AXI_AWVALID & ~s_q.aw_hold;
    w_go = S_AXI_WVALID & ~s_q.w_hold;
    if (aw_go) begin
      s_d.aw_hold = 1'b1;
      s_d.aw_addr = S_AXI_AWADDR;
    end
    if (w_go) begin
      s_d.w_hold = 1'b1;
      s_d.w_data = S_AXI_WDATA;
    end
    if (s_q.aw_hold && s_q.w_hold && !s_q.bvalid) begin
      s_d.bvalid = 1'b1;
      s_d.bresp = DCO_RESP_OKAY;
      s_d.aw_hold = 1'b0;
      s_d.w_hold = 1'b0;
      if (S_AXI_WSTRB[0]) begin
        case (s_q.aw_addr)
          DCO_ADDR_CTRL: s_d.ctrl = s_q.w_data[3:0];
          DCO_ADDR_OE: begin
            s_d.oe_reg = s_q.w_data[7:0];
            s_d.stoppable = s_q.w_data[15:8];
          end
          DCO_ADDR_STAT: s_d.bresp = DCO_RESP_SLVERR;
          default: s_d.bresp = DCO_RESP_SLVERR;
        endcase
      end else if (s_q.aw_addr != DCO_ADDR_CTRL && s_q.aw_addr != DCO_ADDR_OE) begin
        s_d.bresp = DCO_RESP_SLVERR;
      end
    end
    if (s_q.bvalid && S_AXI_BREADY) begin
      s_d.bvalid = 1'b0;
    end
    if (S_AXI_ARVALID && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = DCO_RESP_OKAY;
      case (S_AXI_ARADDR)
        DCO_ADDR_CTRL: s_d.rdata = {28'h0000000, s_q.ctrl};
        DCO_ADDR_OE: s_d.rdata = {16'h0000, s_q.stoppable, s_q.oe_reg};
        DCO_ADDR_STAT: s_d.rdata = {8'h00, 8'(s_q.run), 8'h00, 3'h0,
          s_q.pd, s_q.stop_acc, s_q.half_act, s_q.wide_bw, s_q.bypass};
        default: begin
          s_d.rdata = 32'h00000000;
          s_d.rresp = DCO_RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && S_AXI_RREADY) begin
      s_d.rvalid = 1'b0;
    end

    // ----------------------------------------------------------------
    // Bus readies
    // ----------------------------------------------------------------
    // Readies are kept as flops of their own so the bus sees register outputs.
    s_d.aw_rdy = ~s_d.aw_hold;
    s_d.w_rdy = ~s_d.w_hold;
    s_d.ar_rdy = ~s_d.rvalid;
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      s_q <= '0;
      s_q.ctrl <= DCO_CTRL_RST;
      s_q.oe_reg <= DCO_OE_RST;
      s_q.stoppable <= DCO_STOPPABLE_RST;
      s_q.aw_rdy <= 1'b1;
      s_q.w_rdy <= 1'b1;
      s_q.ar_rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign S_AXI_AWREADY = s_q.aw_rdy;
  assign S_AXI_WREADY = s_q.w_rdy;
  assign S_AXI_BVALID = s_q.bvalid;
  assign S_AXI_BRESP = s_q.bresp;
  assign S_AXI_ARREADY = s_q.ar_rdy;
  assign S_AXI_RVALID = s_q.rvalid;
  assign S_AXI_RDATA = s_q.rdata;
  assign S_AXI_RRESP = s_q.rresp;
  assign TRUE_OUTPUT_LEG_O = s_q.tl;
  assign TRUE_OUTPUT_LEG_OE_O = s_q.tl_oe;
  assign COMPLEMENT_OUTPUT_LEG_O = s_q.cl;
  assign COMPLEMENT_OUTPUT_LEG_OE_O = s_q.cl_oe;
  assign BYPASS_MODE_O = s_q.bypass;
  assign WIDE_BANDWIDTH_O = s_q.wide_bw;
  assign POWER_DOWN_O = s_q.pd;

endmodule // dco_top

//--- rtl/dco_pkg.sv
// Package of constants, register map and carrier types for the clock output control block.
package dco_pkg;

  // ----------------------------------------------------------------
  // Register map (AXI4-Lite byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] DCO_ADDR_CTRL = 4'h0;
  localparam logic [3:0] DCO_ADDR_OE = 4'h4;
  localparam logic [3:0] DCO_ADDR_STAT = 4'h8;

  // Control register field positions.
  localparam int DCO_BIT_HALF_N = 0;
  localparam int DCO_BIT_BYPASS_N = 1;
  localparam int DCO_BIT_WIDE_BW_N = 2;
  localparam int DCO_BIT_STOP_TRI = 3;

  // Reset values.
  localparam logic [3:0] DCO_CTRL_RST = 4'h7;
  localparam logic [7:0] DCO_OE_RST = 8'hFF;
  localparam logic [7:0] DCO_STOPPABLE_RST = 8'hFF;

  localparam logic [1:0] DCO_RESP_OKAY = 2'h0;
  localparam logic [1:0] DCO_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int DCO_CLK_NS = 50;
  localparam int DCO_PARK_HIGH_NS = 15;
  // Longest time, rounded down, never below one cycle.
  localparam int DCO_PARK_HIGH_CYC =
    (DCO_PARK_HIGH_NS / DCO_CLK_NS) < 1 ? 1 : (DCO_PARK_HIGH_NS / DCO_CLK_NS);
  localparam int DCO_LAT_MIN_PER = 2;
  localparam int DCO_LAT_MAX_PER = 6;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DCO_RUN,
    DCO_PARK_HI,
    DCO_FLOAT
  } dco_leg_mode_t;

  // The last member is bit zero, so the register word maps straight onto the fields.
  typedef struct packed {
    logic stop_tri;
    logic wide_bw_n;
    logic bypass_n;
    logic half_rate_n;
  } dco_ctrl_t;

endpackage : dco_pkg

//--- tb/dco_src_model.sv
// Upstream source model: slow reference and PLL clock levels.
`timescale 1ns/1ps
module dco_src_model #(
  parameter int REF_HALF = 5,
  parameter int PLL_HALF = 7
) (
  input wire logic clk_i,
  output logic ref_o,
  output logic pll_o
);
  int rc = 0;
  int pc = 0;
  initial {ref_o, pll_o} = 2'b00;
  // Different rates let the bench tell the bypass path from the PLL path.
  always @(posedge clk_i) begin
    rc <= (rc + 1) % REF_HALF;
    pc <= (pc + 1) % PLL_HALF;
    if (rc == REF_HALF - 1) ref_o <= ~ref_o;
    if (pc == PLL_HALF - 1) pll_o <= ~pll_o;
  end
endmodule // dco_src_model

//--- tb/dco_properties.sv
// Port assertions for the clock output control block.
`timescale 1ns/1ps
module dco_properties #(
  parameter int NPAIRS = 4
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [NPAIRS-1:0] TRUE_OUTPUT_LEG_O,
  input wire logic [NPAIRS-1:0] TRUE_OUTPUT_LEG_OE_O,
  input wire logic [NPAIRS-1:0] COMPLEMENT_OUTPUT_LEG_O,
  input wire logic [NPAIRS-1:0] COMPLEMENT_OUTPUT_LEG_OE_O,
  input wire logic PLL_SELECT_PIN_I,
  input wire logic WIDE_BANDWIDTH_SELECT_N_I,
  input wire logic BYPASS_MODE_O,
  input wire logic WIDE_BANDWIDTH_O
);
  wire logic [NPAIRS-1:0] tl = TRUE_OUTPUT_LEG_O;
  wire logic [NPAIRS-1:0] te = TRUE_OUTPUT_LEG_OE_O;
  wire logic [NPAIRS-1:0] ce = COMPLEMENT_OUTPUT_LEG_OE_O;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered");
  a_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
    else $error("read answer dropped");
  a_arready_excl: assert property (S_AXI_ARREADY != S_AXI_RVALID)
    else $error("read ready wrong");
  a_float_pair: assert property ((ce & ~te) == '0)
    else $error("complement driven alone");
  // One cycle of grace; the design raises the true leg in the same cycle a pair parks.
  a_park_high: assert property ((te & ~ce & $past(te & ~ce) & ~tl) == '0)
    else $error("parked leg not high");
  a_legs_opposed: assert property ((te & ce & ~(tl ^ COMPLEMENT_OUTPUT_LEG_O)) == '0)
    else $error("legs not opposed");
  a_bypass_pin: assert property (!PLL_SELECT_PIN_I [*6] |-> BYPASS_MODE_O)
    else $error("bypass pin ignored");
  a_wide_pin: assert property (!WIDE_BANDWIDTH_SELECT_N_I [*6] |-> WIDE_BANDWIDTH_O)
    else $error("bandwidth pin ignored");
  c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
  c_parked: cover property (te[0] && !ce[0] && tl[0]);
  c_floated: cover property ($fell(te[0]));
endmodule // dco_properties
bind dco_top dco_properties #(.NPAIRS(NPAIRS)) i_props (.*);

//--- tb/diff_clock_output_control_bench.sv
// Self-checking bench for the clock output control block.
`timescale 1ns/1ps
module diff_clock_output_control_bench;
  import dco_pkg::*;
  logic REF_CLK_I, RST_I, REF_LEVEL_I, PLL_LEVEL_I, POLARITY_STRAP_I, CLOCK_STOP_REQUEST_I;
  logic POWER_DOWN_REQUEST_I, PLL_SELECT_PIN_I, WIDE_BANDWIDTH_SELECT_N_I, on_lvl;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic BYPASS_MODE_O, WIDE_BANDWIDTH_O, POWER_DOWN_O;
  logic [1:0] OE_PIN_I, S_AXI_BRESP, S_AXI_RRESP;
  logic [3:0] S_AXI_AWADDR, S_AXI_WSTRB, S_AXI_ARADDR, TRUE_OUTPUT_LEG_O, TRUE_OUTPUT_LEG_OE_O;
  logic [3:0] COMPLEMENT_OUTPUT_LEG_O, COMPLEMENT_OUTPUT_LEG_OE_O;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, r;
  logic [3:0] ctl [4] = '{4'h7, 4'h5, 4'h4, 4'h5};
  int tg [4] = '{40, 56, 28, 56};
  int miscompares = 0;
  int samples_checked = 0;
  dco_top i_dut (.*);
  dco_src_model i_src (.clk_i(REF_CLK_I), .ref_o(REF_LEVEL_I), .pll_o(PLL_LEVEL_I));
  initial begin
    REF_CLK_I = 1'b0;
    forever #25 REF_CLK_I = ~REF_CLK_I;
  end
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d, input logic [1:0] rs);
    int n;
    n = 0;
    @(posedge REF_CLK_I);
    S_AXI_AWADDR <= a;
    S_AXI_ARADDR <= a;
    S_AXI_WDATA <= d;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= {3{w}};
    {S_AXI_ARVALID, S_AXI_RREADY} <= {2{!w}};
    do begin
      @(posedge REF_CLK_I);
      n++;
      if (n > 100) begin
        miscompares++;
        report_and_stop();
      end
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!(S_AXI_BVALID && S_AXI_BREADY) && !(S_AXI_RVALID && S_AXI_RREADY));
    {S_AXI_BREADY, S_AXI_RREADY} <= 2'b00;
    chk(w ? 32'(S_AXI_BRESP) : 32'(S_AXI_RRESP), 32'(rs));
    if (!w) chk(S_AXI_RDATA, d);
  endtask
  // Toggle count of pair 0 over 280 cycles; phase alone can shift it by one.
  task automatic rate(input int want);
    int n;
    int bad;
    logic p;
    n = 0;
    bad = 0;
    p = TRUE_OUTPUT_LEG_O[0];
    repeat (280) begin
      @(posedge REF_CLK_I);
      n += int'(TRUE_OUTPUT_LEG_O[0] !== p);
      bad += int'(COMPLEMENT_OUTPUT_LEG_O[0] !== ~TRUE_OUTPUT_LEG_O[0]);
      p = TRUE_OUTPUT_LEG_O[0];
    end
    chk(32'(n > want - 3 && n < want + 3), 32'h1);
    chk(32'(bad), 32'h0);
  endtask
  // Eighty cycles cover six output periods plus synchronisers and debounce.
  task automatic settle(input logic [7:0] want);
    repeat (80) @(posedge REF_CLK_I);
    chk(32'({TRUE_OUTPUT_LEG_OE_O, COMPLEMENT_OUTPUT_LEG_OE_O}), 32'(want));
  endtask
  initial begin
    {RST_I, POLARITY_STRAP_I, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = '0;
    {S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    {PLL_SELECT_PIN_I, WIDE_BANDWIDTH_SELECT_N_I} = 2'h3;
    S_AXI_WSTRB = 4'hF;
    r = $urandom(32'hE23CDC0F);
    for (int p = 0; p < 2; p++) begin
      on_lvl = !p[0];
      POLARITY_STRAP_I <= p[0];
      OE_PIN_I <= {2{on_lvl}};
      CLOCK_STOP_REQUEST_I <= on_lvl;
      POWER_DOWN_REQUEST_I <= on_lvl;
      RST_I <= 1'b1;
      repeat (12) @(posedge REF_CLK_I);
      RST_I <= 1'b0;
      repeat (3) @(posedge REF_CLK_I);
      POLARITY_STRAP_I <= on_lvl;
      bus(1'b0, DCO_ADDR_CTRL, 32'h7, DCO_RESP_OKAY);
      bus(1'b0, DCO_ADDR_OE, 32'hFFFF, DCO_RESP_OKAY);
      bus(1'b0, 4'hC, 32'h0, DCO_RESP_SLVERR);
      bus(1'b1, DCO_ADDR_STAT, 32'h0, DCO_RESP_SLVERR);
      for (int i = 0; i < 4; i++) begin
        bus(1'b1, DCO_ADDR_CTRL, {28'h0, ctl[i]}, DCO_RESP_OKAY);
        repeat (200) @(posedge REF_CLK_I);
        chk(32'(BYPASS_MODE_O), 32'(!ctl[i][1]));
        rate(tg[i]);
      end
      OE_PIN_I[0] <= !on_lvl;
      settle(8'hEE);
      OE_PIN_I[0] <= on_lvl;
      settle(8'hFF);
      bus(1'b1, DCO_ADDR_OE, 32'hFF0B, DCO_RESP_OKAY);
      settle(8'hBB);
      CLOCK_STOP_REQUEST_I <= !on_lvl;
      settle(8'hB0);
      chk(32'(TRUE_OUTPUT_LEG_O & 4'hB), 32'hB);
      CLOCK_STOP_REQUEST_I <= on_lvl;
      settle(8'hBB);
      bus(1'b1, DCO_ADDR_CTRL, 32'hD, DCO_RESP_OKAY);
      CLOCK_STOP_REQUEST_I <= !on_lvl;
      settle(8'h00);
      CLOCK_STOP_REQUEST_I <= on_lvl;
      settle(8'hBB);
      POWER_DOWN_REQUEST_I <= !on_lvl;
      settle(8'hB0);
      chk(32'(POWER_DOWN_O), 32'h1);
      POWER_DOWN_REQUEST_I <= on_lvl;
      repeat (8) begin
        r = $urandom;
        PLL_SELECT_PIN_I <= r[0];
        WIDE_BANDWIDTH_SELECT_N_I <= r[1];
        bus(1'b1, DCO_ADDR_CTRL, {28'h0, r[4:2], 1'b1}, DCO_RESP_OKAY);
        repeat (8) @(posedge REF_CLK_I);
        chk(32'(BYPASS_MODE_O), 32'(!(r[0] & r[2])));
        chk(32'(WIDE_BANDWIDTH_O), 32'(!(r[1] & r[3])));
      end
      PLL_SELECT_PIN_I <= 1'b1;
      WIDE_BANDWIDTH_SELECT_N_I <= 1'b1;
    end
    report_and_stop();
  end
endmodule // diff_clock_output_control_bench
